// [rtl/efps_top.sv]
// Contract
// - Switch off on bias or input undervoltage
// - Written undervoltage threshold is applied
// - Enable input compared at two levels
// - Middle enable: off, discharge after qualify
// - Shutdown level clears faults, flags, config
// - Insertion delay after bias, ignoring enable
// - Insertion delay is programmable
// - Overvoltage turns switch off promptly
// - Below falling threshold, ramp back on
// - Slew field bits 10:9 select ramp factor
// - Start-up timeout flags fault
// - Timeout sets bit 6, fault low, retry
// - Four overcurrent tiers
// - Breaker trips after full blanking interval
// - Reference from register or reference pin
// - Conduct only with both enables high
// - Blanking timer restarts when overcurrent clears
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module efps_top #(
	parameter int unsigned INSERTION_DELAY_SETTING_DEF = efps_pkg::INSERTION_DELAY_SETTING_CYC,
	parameter int unsigned QOD_LIM = efps_pkg::QOD_CYC,
	parameter int unsigned SU_TMR_LIM = efps_pkg::SU_TMR_CYC,
	parameter int unsigned RETRY_LIM = efps_pkg::RETRY_CYC
) (
	input wire logic sys_clk, // 250 MHz clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic bias_ok, // Bias supply above fixed threshold
	input wire logic enable_undervoltage_input, // Enable above on level
	input wire logic enable_above_shutdown, // Enable above shutdown level
	input wire logic switch_enable_input, // Switch enable pin
	input wire logic [11:0] vin_code, // Input voltage code
	input wire logic [11:0] current_monitor_code, // Sensed current code
	input wire logic [11:0] reference_pin_code, // External reference code
	input wire logic fast_trip_det, // Fast-trip comparator
	input wire logic switch_fully_on, // Switch fully enhanced
	output logic switch_on, // Switch gate enable
	output logic ramp_active, // Slew-controlled ramp running
	output logic [1:0] slew_scale, // Ramp factor code to slew stage
	output logic current_limit, // Start-up current regulation
	output logic discharge, // Output discharge enable
	output logic fault_output_n, // Fault output, active low
	output logic irq // Interrupt, active high level
);
	logic [31:0] config_q;
	logic [11:0] uv_thr_q;
	logic [11:0] ov_thr_q;
	logic [11:0] ov_hyst_q;
	logic [11:0] oc_ref_q;
	logic [31:0] insertion_delay_setting_q;
	logic [31:0] blank_q;
	logic [6:0] status_q;
	logic [6:0] mask_q;
	logic [6:0] status_set;
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic pready_q;
	logic pslverr_q;
	logic rd_ok;
	logic access_go;
	logic wr_go;
	efps_pkg::efps_state_e state_q;
	logic [31:0] ins_cnt_q;
	logic [31:0] qod_cnt_q;
	logic [31:0] su_cnt_q;
	logic [31:0] blank_cnt_q;
	logic [31:0] retry_cnt_q;
	logic ov_q;
	logic sd_clear;
	logic uv_lock;
	logic oc_det;
	logic both_en;
	logic [11:0] oc_ref;
	logic [11:0] ov_fall;
	logic cb_trip;
	logic su_tmo;
	logic ft_trip;
	logic retry_auto;
	logic run_ok;
	logic start_go;
	logic sw_d;
	logic sw_q;
	logic ramp_q;
	logic ilim_q;
	logic dis_q;
	logic flt_n_q;
	logic irq_q;
	logic [1:0] slew_q;

	// Shutdown level behaves as a full reset of soft state
	assign sd_clear = !enable_above_shutdown;
	assign uv_lock = !bias_ok || (vin_code < uv_thr_q);
	assign both_en = enable_undervoltage_input
		&& switch_enable_input;
	assign oc_ref = config_q[efps_pkg::CFG_REF_EXT] ?
		reference_pin_code : oc_ref_q;
	assign oc_det = current_monitor_code > oc_ref;
	assign ov_fall = (ov_thr_q > ov_hyst_q) ?
		(ov_thr_q - ov_hyst_q) : 12'h000;
	assign retry_auto = config_q[efps_pkg::CFG_RETRY];
	assign cb_trip = (state_q == efps_pkg::S_ON) && oc_det
		&& (blank_cnt_q >= blank_q);
	assign ft_trip = fast_trip_det && ((state_q == efps_pkg::S_ON)
		|| (state_q == efps_pkg::S_START));
	assign su_tmo = (state_q == efps_pkg::S_START) && !switch_fully_on
		&& (su_cnt_q >= SU_TMR_LIM - 1);
	assign wr_go = psel && penable && pready_q && pwrite;
	assign access_go = psel && penable && !pready_q;
	// Leaving idle and staying on share one gate condition, so the
	// switch and its ramp rise on the same edge; the current limit waits for S_START
	assign run_ok = both_en && !uv_lock && !ov_q;
	assign start_go = (state_q == efps_pkg::S_IDLE) && bias_ok && run_ok;
	assign sw_d = (start_go || (state_q == efps_pkg::S_START)
		|| (state_q == efps_pkg::S_ON)) && run_ok && !ft_trip
		&& !cb_trip && !su_tmo;

	always_comb begin
		rd_ok = 1'b1;
		rd_d = 32'h0000_0000;
		case (paddr)
		efps_pkg::ADDR_CONFIG: rd_d = config_q;
		efps_pkg::ADDR_UV_THR: rd_d = {20'h00000, uv_thr_q};
		efps_pkg::ADDR_OV_THR: rd_d = {20'h00000, ov_thr_q};
		efps_pkg::ADDR_OV_HYST: rd_d = {20'h00000, ov_hyst_q};
		efps_pkg::ADDR_INSERTION_DELAY_SETTING: rd_d = insertion_delay_setting_q;
		efps_pkg::ADDR_BLANK: rd_d = blank_q;
		efps_pkg::ADDR_OC_REF: rd_d = {20'h00000, oc_ref_q};
		efps_pkg::ADDR_STATUS: rd_d = {25'h0000000, status_q};
		efps_pkg::ADDR_MASK: rd_d = {25'h0000000, mask_q};
		efps_pkg::ADDR_STATE: rd_d = {24'h000000, ov_q, uv_lock,
			sw_q, dis_q, 1'b0, state_q};
		default: rd_ok = 1'b0;
		endcase
	end

	// One wait state so that read data comes from a flip-flop
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access_go;
		end
	end

	// Write data is not echoed, so a write reads back as zero
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prdata_q <= 32'h0000_0000;
		end else if (access_go) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= access_go && !rd_ok;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			config_q <= efps_pkg::CONFIG_RST;
			uv_thr_q <= efps_pkg::UV_THR_RST;
			ov_thr_q <= efps_pkg::OV_THR_RST;
			ov_hyst_q <= efps_pkg::OV_HYST_RST;
			insertion_delay_setting_q <= INSERTION_DELAY_SETTING_DEF;
			blank_q <= efps_pkg::BLANK_RST;
			oc_ref_q <= efps_pkg::OC_REF_RST;
			mask_q <= efps_pkg::MASK_RST;
		end else if (wr_go) begin
			case (paddr)
			efps_pkg::ADDR_CONFIG: config_q <= pwdata;
			efps_pkg::ADDR_UV_THR: uv_thr_q <= pwdata[11:0];
			efps_pkg::ADDR_OV_THR: ov_thr_q <= pwdata[11:0];
			efps_pkg::ADDR_OV_HYST: ov_hyst_q <= pwdata[11:0];
			efps_pkg::ADDR_INSERTION_DELAY_SETTING: insertion_delay_setting_q <= pwdata;
			efps_pkg::ADDR_BLANK: blank_q <= pwdata;
			efps_pkg::ADDR_OC_REF: oc_ref_q <= pwdata[11:0];
			efps_pkg::ADDR_MASK: mask_q <= pwdata[6:0];
			default: ;
			endcase
		end
	end

	always_comb begin
		status_set = 7'h00;
		status_set[efps_pkg::ST_UV] = uv_lock && (state_q != efps_pkg::S_OFF);
		status_set[efps_pkg::ST_OV] = ov_q;
		status_set[efps_pkg::ST_CB] = cb_trip;
		status_set[efps_pkg::ST_FT] = ft_trip;
		status_set[efps_pkg::ST_OC_DET] = (state_q == efps_pkg::S_ON)
			&& oc_det;
		status_set[efps_pkg::ST_SU_TMO] = su_tmo;
	end

	// Set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			status_q <= 7'h00;
		end else if (wr_go && (paddr == efps_pkg::ADDR_STATUS)) begin
			status_q <= (status_q & ~pwdata[6:0]) | status_set;
		end else begin
			status_q <= status_q | status_set;
		end
	end

	// Overvoltage comparator with hysteresis
	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			ov_q <= 1'b0;
		end else if (vin_code > ov_thr_q) begin
			ov_q <= 1'b1;
		end else if (vin_code < ov_fall) begin
			ov_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			state_q <= efps_pkg::S_OFF;
		end else begin
			case (state_q)
			efps_pkg::S_OFF:
				if (bias_ok) state_q <= efps_pkg::S_INSERT;
			efps_pkg::S_INSERT: begin
				// Enable is ignored until the delay expires
				if (!bias_ok) state_q <= efps_pkg::S_OFF;
				else if (ins_cnt_q >= insertion_delay_setting_q)
					state_q <= efps_pkg::S_IDLE;
			end
			efps_pkg::S_IDLE: begin
				if (!bias_ok) state_q <= efps_pkg::S_OFF;
				else if (both_en && !uv_lock && !ov_q)
					state_q <= efps_pkg::S_START;
			end
			efps_pkg::S_START: begin
				if (ft_trip || su_tmo) state_q <= efps_pkg::S_FAULT;
				else if (!both_en || uv_lock || ov_q)
					state_q <= efps_pkg::S_IDLE;
				else if (switch_fully_on)
					state_q <= efps_pkg::S_ON;
			end
			efps_pkg::S_ON: begin
				if (ft_trip || cb_trip) state_q <= efps_pkg::S_FAULT;
				else if (!both_en || uv_lock || ov_q)
					state_q <= efps_pkg::S_IDLE;
			end
			efps_pkg::S_FAULT: begin
				if (retry_auto && retry_cnt_q >= RETRY_LIM - 1)
					state_q <= efps_pkg::S_IDLE;
				else if (!enable_undervoltage_input)
					state_q <= efps_pkg::S_IDLE;
			end
			default: state_q <= efps_pkg::S_OFF;
			endcase
		end
	end

	// Timers restart whenever their entry condition is absent
	always_ff @(posedge sys_clk) begin
		if (!nrst || state_q != efps_pkg::S_INSERT) begin
			ins_cnt_q <= 32'h0000_0000;
		end else if (ins_cnt_q < insertion_delay_setting_q) begin
			ins_cnt_q <= ins_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || state_q != efps_pkg::S_START) begin
			su_cnt_q <= 32'h0000_0000;
		end else if (su_cnt_q < SU_TMR_LIM) begin
			su_cnt_q <= su_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || state_q != efps_pkg::S_ON || !oc_det) begin
			blank_cnt_q <= 32'h0000_0000;
		end else if (blank_cnt_q < blank_q) begin
			blank_cnt_q <= blank_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || state_q != efps_pkg::S_FAULT) begin
			retry_cnt_q <= 32'h0000_0000;
		end else if (retry_cnt_q < RETRY_LIM) begin
			retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
		end
	end

	// Middle enable region: digital state kept, discharge after qualify
	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear || enable_undervoltage_input) begin
			qod_cnt_q <= 32'h0000_0000;
			dis_q <= 1'b0;
		end else if (qod_cnt_q >= QOD_LIM - 1) begin
			dis_q <= 1'b1;
		end else begin
			qod_cnt_q <= qod_cnt_q + 32'h0000_0001;
		end
	end

	// Switch drops in the same edge as the cause, one edge later for overvoltage via ov_q, well inside response time
	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			sw_q <= 1'b0;
		end else begin
			sw_q <= sw_d;
		end
	end

	// Ramp starts with the gate so every turn-on is slew controlled
	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			ramp_q <= 1'b0;
		end else begin
			ramp_q <= sw_d && !switch_fully_on && (start_go
				|| state_q == efps_pkg::S_START);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			ilim_q <= 1'b0;
		end else begin
			ilim_q <= sw_d && (state_q == efps_pkg::S_START)
				&& oc_det;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			slew_q <= 2'b10;
		end else begin
			slew_q <= config_q[efps_pkg::CFG_SLEW_HI:efps_pkg::CFG_SLEW_LO];
		end
	end

	// Fault pin follows the latched fault state and its causes
	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			flt_n_q <= 1'b1;
		end else begin
			flt_n_q <= !((state_q == efps_pkg::S_FAULT) || su_tmo
				|| ft_trip || cb_trip);
		end
	end

	// New sets count at once so a same-cycle clear cannot hide them
	always_ff @(posedge sys_clk) begin
		if (!nrst || sd_clear) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |((status_q | status_set) & mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign switch_on = sw_q;
	assign ramp_active = ramp_q;
	assign slew_scale = slew_q;
	assign current_limit = ilim_q;
	assign discharge = dis_q;
	assign fault_output_n = flt_n_q;
	assign irq = irq_q;
endmodule
`default_nettype wire

// [pkg/efps_pkg.sv]
package efps_pkg;
	localparam int unsigned CLK_MHZ = 250;
	// Times in their own units; cycle counts derive from the clock rate
	localparam int unsigned INSERTION_DELAY_US = 1000;
	localparam int unsigned DISCHARGE_QUALIFY_US = 100;
	localparam int unsigned STARTUP_TIMEOUT_US = 50000;
	localparam int unsigned RETRY_DELAY_US = 1000;
	localparam int unsigned OVERVOLTAGE_RESPONSE_NS = 1000;
	localparam int unsigned INSERTION_DELAY_SETTING_CYC = INSERTION_DELAY_US * CLK_MHZ;
	localparam int unsigned QOD_CYC = DISCHARGE_QUALIFY_US * CLK_MHZ;
	localparam int unsigned SU_TMR_CYC = STARTUP_TIMEOUT_US * CLK_MHZ;
	localparam int unsigned RETRY_CYC = RETRY_DELAY_US * CLK_MHZ;
	// Longest time rounds down; the design answers in two cycles anyway
	localparam int unsigned OVP_CYC = (OVERVOLTAGE_RESPONSE_NS * CLK_MHZ)
		/ 1000;
	// Register byte addresses
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_UV_THR = 8'h04;
	localparam logic [7:0] ADDR_OV_THR = 8'h08;
	localparam logic [7:0] ADDR_OV_HYST = 8'h0c;
	localparam logic [7:0] ADDR_INSERTION_DELAY_SETTING = 8'h10;
	localparam logic [7:0] ADDR_BLANK = 8'h14;
	localparam logic [7:0] ADDR_OC_REF = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_MASK = 8'h20;
	localparam logic [7:0] ADDR_STATE = 8'h24;
	// Configuration field positions
	localparam int unsigned CFG_RETRY = 0;
	localparam int unsigned CFG_REF_EXT = 1;
	localparam int unsigned CFG_SLEW_LO = 9;
	localparam int unsigned CFG_SLEW_HI = 10;
	// Status bit positions
	localparam int unsigned ST_UV = 0;
	localparam int unsigned ST_OV = 1;
	localparam int unsigned ST_CB = 2;
	localparam int unsigned ST_FT = 3;
	localparam int unsigned ST_OC_DET = 4;
	localparam int unsigned ST_SU_TMO = 6;
	// Reset values
	localparam logic [31:0] CONFIG_RST = 32'h0000_0400;
	localparam logic [11:0] UV_THR_RST = 12'h200;
	localparam logic [11:0] OV_THR_RST = 12'hc00;
	localparam logic [11:0] OV_HYST_RST = 12'h040;
	localparam logic [31:0] BLANK_RST = 32'h0000_03e8;
	localparam logic [11:0] OC_REF_RST = 12'h800;
	localparam logic [6:0] MASK_RST = 7'h00;
	typedef enum logic [2:0] {
		S_OFF, S_INSERT, S_IDLE, S_START, S_ON, S_FAULT
	} efps_state_e;
endpackage

// [test/efps_power_stage.sv]
`timescale 1ns/10ps
`default_nettype none
module efps_power_stage (
	input wire logic sys_clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic switch_on, // Gate enable from block
	input wire logic [7:0] lag, // Cycles to full on minus one, 0 never
	output logic switch_fully_on // Switch fully enhanced
);
	logic [7:0] cnt_q;
	// Zero lag models a stuck gate so the start-up timeout can be hit
	always_ff @(posedge sys_clk) begin
		if (!nrst || !switch_on) begin
			cnt_q <= 8'h00;
			switch_fully_on <= 1'b0;
		end else if (lag != 8'h00) begin
			if (cnt_q == lag)
				switch_fully_on <= 1'b1;
			else
				cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule
`default_nettype wire

// [test/efps_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module efps_checker (
	input wire logic sys_clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic bias_ok, // Bias good
	input wire logic enable_undervoltage_input, // Enable on level
	input wire logic enable_above_shutdown, // Enable above shutdown
	input wire logic switch_enable_input, // Switch enable
	input wire logic switch_on, // Gate enable
	input wire logic ramp_active, // Ramp running
	input wire logic current_limit, // Start-up regulation
	input wire logic discharge, // Output discharge
	input wire logic fault_output_n, // Fault, active low
	input wire logic irq, // Interrupt
	input wire logic [1:0] slew_scale // Ramp factor code
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_bias_off:
	assert property (!bias_ok |=> !switch_on) else $error("on without bias");
	a_both_en:
	assert property (!switch_enable_input || !enable_undervoltage_input
		|=> !switch_on) else $error("on without both enables");
	a_ins_hold:
	assert property ($rose(bias_ok) |-> !switch_on [*8])
		else $error("on during insertion delay");
	a_ramp_rise:
	assert property ($rose(switch_on) |-> ramp_active)
		else $error("switch on without ramp");
	a_shut_clear:
	assert property (!enable_above_shutdown |=> fault_output_n && !irq
		&& slew_scale == 2'b10) else $error("shutdown kept state");
	a_fault_off:
	assert property ($fell(fault_output_n) |-> ##[0:1] !switch_on)
		else $error("fault with switch on");
	a_dis_off:
	assert property (discharge |-> !switch_on)
		else $error("discharge while on");
	a_limit_on:
	assert property (current_limit |-> switch_on)
		else $error("limit while off");
endmodule
bind efps_top efps_checker u_chk (.sys_clk, .nrst, .bias_ok,
	.enable_undervoltage_input, .enable_above_shutdown,
	.switch_enable_input, .switch_on, .ramp_active, .current_limit,
	.discharge, .fault_output_n, .irq, .slew_scale);
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, bias_ok = 1'b0, enable_undervoltage_input = 1'b1;
	logic enable_above_shutdown = 1'b1, switch_enable_input = 1'b1;
	logic [7:0] paddr = 8'h00, lag = 8'h03;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr, switch_on, ramp_active, current_limit;
	logic discharge, fault_output_n, irq, switch_fully_on;
	logic [1:0] slew_scale;
	logic [11:0] vin_code = 12'h400, current_monitor_code = 12'h100;
	logic [11:0] reference_pin_code = 12'h000;
	logic fast_trip_det = 1'b0;
	int failures = 0, total_checks = 0, cycles = 0, wn;
	always #2 sys_clk = ~sys_clk;
	efps_top #(.INSERTION_DELAY_SETTING_DEF(20), .QOD_LIM(10), .SU_TMR_LIM(50),
		.RETRY_LIM(10)) dut (.sys_clk, .nrst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .bias_ok,
		.enable_undervoltage_input, .enable_above_shutdown,
		.switch_enable_input, .vin_code, .current_monitor_code,
		.reference_pin_code, .fast_trip_det,
		.switch_fully_on, .switch_on, .ramp_active, .slew_scale,
		.current_limit, .discharge, .fault_output_n, .irq);
	efps_power_stage u_ps (.sys_clk, .nrst, .switch_on, .lag,
		.switch_fully_on);
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, got);
		total_checks++;
		if (got !== ex) begin
			failures++;
			$display("wrong value %s exp %h got %h", nm, ex, got);
		end
	endtask
	task automatic wt(input logic v);
		wn = 0;
		while (switch_on !== v && wn < 100) begin
			@(posedge sys_clk);
			wn++;
		end
	endtask
	task automatic t_regs();
		apb(1'b0, 8'h00, 32'h0);
		chk("config", 32'h400, rdat);
		apb(1'b0, 8'h04, 32'h0);
		chk("uv thr", 32'h200, rdat);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, rerr);
		$display("regs done");
	endtask
	task automatic t_slew();
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, 32'(i) << 9);
			repeat (2) @(posedge sys_clk);
			chk("slew", 32'(i), slew_scale);
		end
		apb(1'b1, 8'h00, 32'h400);
		$display("slew done");
	endtask
	task automatic t_insert();
		bias_ok <= 1'b1;
		wt(1'b1);
		chk("ins delay", 32'h1, wn >= 20 && wn < 30);
		repeat (8) @(posedge sys_clk);
		apb(1'b0, 8'h24, 32'h0);
		chk("state on", 32'h4, rdat[2:0]);
		switch_enable_input <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("switch_enable_input off", 32'h0, switch_on);
		switch_enable_input <= 1'b1;
		$display("insert done");
	endtask
	task automatic t_uv();
		apb(1'b1, 8'h04, 32'h500);
		repeat (2) @(posedge sys_clk);
		chk("uv off", 32'h0, switch_on);
		apb(1'b1, 8'h04, 32'h200);
		wt(1'b1);
		chk("uv back", 32'h1, switch_on);
		$display("uv done");
	endtask
	task automatic t_ov();
		apb(1'b1, 8'h20, 32'h2);
		vin_code <= 12'hd00;
		repeat (3) @(posedge sys_clk);
		chk("ov off", 32'h0, switch_on);
		chk("ov irq", 32'h1, irq);
		vin_code <= 12'hbd0;
		repeat (3) @(posedge sys_clk);
		chk("ov hyst", 32'h0, switch_on);
		vin_code <= 12'h400;
		wt(1'b1);
		chk("ov ramp", 32'h1, ramp_active);
		apb(1'b1, 8'h1c, 32'h2);
		repeat (2) @(posedge sys_clk);
		chk("irq clr", 32'h0, irq);
		$display("ov done");
	endtask
	task automatic t_cb();
		repeat (8) @(posedge sys_clk);
		apb(1'b1, 8'h14, 32'h6);
		current_monitor_code <= 12'h900;
		repeat (4) @(posedge sys_clk);
		current_monitor_code <= 12'h100;
		repeat (2) @(posedge sys_clk);
		current_monitor_code <= 12'h900;
		repeat (4) @(posedge sys_clk);
		chk("cb restart", 32'h1, switch_on);
		wt(1'b0);
		chk("cb trip", 32'h1, wn < 6);
		chk("cb fault", 32'h0, fault_output_n);
		current_monitor_code <= 12'h100;
		apb(1'b0, 8'h1c, 32'h0);
		chk("cb status", 32'h1, rdat[2]);
		enable_undervoltage_input <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("no dis yet", 32'h0, discharge);
		repeat (12) @(posedge sys_clk);
		chk("discharge", 32'h1, discharge);
		enable_above_shutdown <= 1'b0;
		repeat (2) @(posedge sys_clk);
		enable_above_shutdown <= 1'b1;
		enable_undervoltage_input <= 1'b1;
		apb(1'b0, 8'h1c, 32'h0);
		chk("sd status", 32'h0, rdat);
		apb(1'b0, 8'h14, 32'h0);
		chk("sd blank", 32'h3e8, rdat);
		$display("breaker done");
	endtask
	task automatic t_sutmo();
		lag <= 8'h00;
		wt(1'b1);
		current_monitor_code <= 12'h900;
		repeat (3) @(posedge sys_clk);
		chk("start limit", 32'h1, current_limit);
		current_monitor_code <= 12'h100;
		wt(1'b0);
		chk("su time", 32'h1, wn >= 46 && wn <= 50);
		chk("su fault", 32'h0, fault_output_n);
		apb(1'b0, 8'h1c, 32'h0);
		chk("su status", 32'h1, rdat[6]);
		$display("timeout done");
	endtask
	task automatic t_retry();
		lag <= 8'h03;
		reference_pin_code <= 12'h300;
		apb(1'b1, 8'h00, 32'h403);
		wt(1'b1);
		chk("auto retry", 32'h1, wn <= 5);
		repeat (8) @(posedge sys_clk);
		current_monitor_code <= 12'h400;
		repeat (3) @(posedge sys_clk);
		current_monitor_code <= 12'h100;
		apb(1'b0, 8'h1c, 32'h0);
		chk("ext ref", 32'h1, rdat[4]);
		fast_trip_det <= 1'b1;
		wt(1'b0);
		chk("fast trip", 32'h1, wn <= 2);
		chk("ft fault", 32'h0, fault_output_n);
		fast_trip_det <= 1'b0;
		wt(1'b1);
		chk("ft retry", 32'h1, wn >= 9 && wn <= 13);
		apb(1'b0, 8'h1c, 32'h0);
		chk("ft status", 32'h1, rdat[3]);
		$display("retry done");
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		t_regs();
		t_slew();
		t_insert();
		t_uv();
		t_ov();
		t_cb();
		t_sutmo();
		t_retry();
		final_report();
	end
endmodule
`default_nettype wire
